// file: rtl/rsc_config_regs.sv
// receive chain and synthesizer configuration registers behind a serial port
module rsc_config_regs
  import rsc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // serial port pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo_out,
  output logic sdo_oe,
  // pll lock detector and lock pin
  input wire logic pll_locked,
  output logic lock_pin,
  // chip mode
  output logic [2:0] chip_operating_mode,
  output logic mode_sleep,
  output logic mode_standby,
  output logic mode_synth,
  output logic mode_receive,
  output logic mode_transmit,
  // receive chain settings
  output logic [1:0] if_amp_gain_sel,
  output logic [3:0] passive_filter_bw_sel,
  output logic bandpass_filter_select,
  output logic [3:0] second_filter_bw_sel,
  output logic [3:0] bandpass_center_sel,
  output logic [7:0] freq_deviation_setting,
  output logic [7:0] ook_low_if,
  // synthesizer
  output logic divider_set_select,
  output logic [7:0] active_ref_div,
  output logic [7:0] active_p_div,
  output logic [7:0] active_s_div,
  output logic [15:0] feedback_ratio
);
  import rsc_pkg::*;

  // ********************
  // pin synchronisers
  // ********************
  logic [SYNC_N-1:0] pins;
  logic s1 [SYNC_N];
  logic s2 [SYNC_N];
  logic s3 [SYNC_N];
  logic lvl_reg [SYNC_N];
  logic rise [SYNC_N];
  logic fall [SYNC_N];

  assign pins = {pll_locked, sdi, cs_n, sck};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          s1[gi] <= SYNC_RST[gi];
          s2[gi] <= SYNC_RST[gi];
          s3[gi] <= SYNC_RST[gi];
          lvl_reg[gi] <= SYNC_RST[gi];
        end else begin
          s1[gi] <= pins[gi];
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          // a change counts only once the last two stages agree
          if (s2[gi] == s3[gi]) begin
            lvl_reg[gi] <= s3[gi];
          end
        end
      end
      assign rise[gi] = (s2[gi] == s3[gi]) && s3[gi] && !lvl_reg[gi];
      assign fall[gi] = (s2[gi] == s3[gi]) && !s3[gi] && lvl_reg[gi];
    end
  endgenerate

  // ********************
  // register storage
  // ********************
  logic [2:0] mode_reg;
  logic sel_reg;
  logic [1:0] gain_reg;
  logic [7:0] fdev_reg;
  logic [7:0] bw_reg;
  logic [3:0] ctr_reg;
  logic bp_reg;
  logic lock_en_reg;
  logic lock_st_reg;
  logic [7:0] div_reg [DIV_COUNT];
  logic wr_en_reg;
  logic [6:0] wr_addr_reg;
  logic [7:0] wr_data_reg;

  function automatic logic [7:0] rd_mux(input logic [6:0] a);
    logic [7:0] d;
    d = BYTE_RST;
    unique case (a)
      ADDR_MODE_CFG: d = {mode_reg, 4'h0, sel_reg};
      ADDR_GAIN_CFG: d = {6'h00, gain_reg};
      ADDR_FDEV_CFG: d = fdev_reg;
      ADDR_LOCK_CFG: d = {6'h00, lock_st_reg, lock_en_reg};
      ADDR_FILT_BW: d = bw_reg;
      ADDR_FILT_CTR: d = {ctr_reg, 4'h0};
      ADDR_FILT_SEL: d = {bp_reg, 7'h00};
      default: begin
        for (int k = 0; k < DIV_COUNT; k++) begin
          if (a == ADDR_DIV_BASE + 7'(k)) begin
            d = div_reg[k];
          end
        end
      end
    endcase
    return d;
  endfunction

  // ********************
  // serial engine
  // ********************
  rsc_phase_t phase_reg;
  logic [3:0] cnt_reg;
  logic [7:0] rx_reg;
  logic [7:0] cmd_reg;
  logic [7:0] tx_reg;
  logic sdo_reg;
  logic bit_in;

  assign bit_in = s3[SYNC_SDI];

  // sdi is taken at the same synchroniser depth as sck, so setup is kept
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= RSC_CMD;
      cnt_reg <= 4'h0;
      rx_reg <= BYTE_RST;
      cmd_reg <= BYTE_RST;
      tx_reg <= BYTE_RST;
      sdo_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      wr_addr_reg <= 7'h00;
      wr_data_reg <= BYTE_RST;
    end else begin
      wr_en_reg <= 1'b0;
      if (lvl_reg[SYNC_CS]) begin
        phase_reg <= RSC_CMD;
        cnt_reg <= 4'h0;
      end else if (rise[SYNC_SCK]) begin
        rx_reg <= {rx_reg[6:0], bit_in};
        unique case (phase_reg)
          RSC_CMD: begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == CNT_CMD_LAST) begin
              cmd_reg <= {rx_reg[6:0], bit_in};
              tx_reg <= rd_mux({rx_reg[5:0], bit_in});
              phase_reg <= RSC_DATA;
            end
          end
          RSC_DATA: begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == CNT_DATA_LAST) begin
              phase_reg <= RSC_DONE;
              wr_en_reg <= !cmd_reg[CMD_READ_BIT];
              wr_addr_reg <= cmd_reg[6:0];
              wr_data_reg <= {rx_reg[6:0], bit_in};
            end
          end
          RSC_DONE: begin
          end
        endcase
      end else if (fall[SYNC_SCK] && phase_reg == RSC_DATA) begin
        // read data leaves msb first, changed on the falling clock
        sdo_reg <= tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  assign sdo_out = sdo_reg;
  assign sdo_oe = !lvl_reg[SYNC_CS];

  // ********************
  // register writes
  // ********************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= MODE_SLEEP;
      sel_reg <= 1'b0;
      gain_reg <= 2'h0;
      fdev_reg <= BYTE_RST;
      bw_reg <= BYTE_RST;
      ctr_reg <= 4'h0;
      bp_reg <= 1'b0;
      lock_en_reg <= LOCK_EN_RST;
    end else if (wr_en_reg) begin
      unique case (wr_addr_reg)
        ADDR_MODE_CFG: begin
          mode_reg <= wr_data_reg[MODE_MSB:MODE_LSB];
          sel_reg <= wr_data_reg[DIV_SEL_BIT];
        end
        ADDR_GAIN_CFG: gain_reg <= wr_data_reg[GAIN_MSB:0];
        ADDR_FDEV_CFG: fdev_reg <= wr_data_reg;
        ADDR_LOCK_CFG: lock_en_reg <= wr_data_reg[LOCK_EN_BIT];
        ADDR_FILT_BW: bw_reg <= wr_data_reg;
        ADDR_FILT_CTR: ctr_reg <= wr_data_reg[CENTER_MSB:CENTER_LSB];
        ADDR_FILT_SEL: bp_reg <= wr_data_reg[BP_SEL_BIT];
        default: begin
        end
      endcase
    end
  end

  generate
    for (gi = 0; gi < DIV_COUNT; gi++) begin : g_div
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          div_reg[gi] <= BYTE_RST;
        end else if (wr_en_reg && wr_addr_reg == ADDR_DIV_BASE + 7'(gi)) begin
          div_reg[gi] <= wr_data_reg;
        end
      end
    end
  endgenerate

  // ********************
  // pll lock indication
  // ********************
  logic lock_clr;
  logic lock_pin_reg;

  assign lock_clr = wr_en_reg && wr_addr_reg == ADDR_LOCK_CFG &&
                    wr_data_reg[LOCK_ST_BIT];

  // a lock arriving with the clear still sets the bit
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_st_reg <= 1'b0;
    end else if (rise[SYNC_LOCK]) begin
      lock_st_reg <= 1'b1;
    end else if (lock_clr) begin
      lock_st_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_pin_reg <= 1'b0;
    end else begin
      lock_pin_reg <= lock_en_reg && lvl_reg[SYNC_LOCK];
    end
  end

  assign lock_pin = lock_pin_reg;

  // ********************
  // decoded outputs
  // ********************
  int unsigned set_base;
  assign set_base = sel_reg ? DIV_SET_STRIDE : 0;

  assign chip_operating_mode = mode_reg;
  assign mode_sleep = mode_reg == MODE_SLEEP;
  assign mode_standby = mode_reg == MODE_STANDBY;
  assign mode_synth = mode_reg == MODE_SYNTH;
  assign mode_receive = mode_reg == MODE_RECEIVE;
  assign mode_transmit = mode_reg == MODE_TRANSMIT;
  assign if_amp_gain_sel = gain_reg;
  assign passive_filter_bw_sel = bw_reg[PASSIVE_BW_MSB:PASSIVE_BW_LSB];
  assign second_filter_bw_sel = bw_reg[SECOND_BW_MSB:0];
  assign bandpass_filter_select = bp_reg;
  assign bandpass_center_sel = ctr_reg;
  assign freq_deviation_setting = fdev_reg;
  // low IF only exists in the band-pass receive path
  assign ook_low_if = (mode_receive && bp_reg) ? fdev_reg : BYTE_RST;
  assign divider_set_select = sel_reg;
  // set switch is combinational: no rewrite, no wait for a transfer
  assign active_ref_div = div_reg[set_base + DIV_R];
  assign active_p_div = div_reg[set_base + DIV_P];
  assign active_s_div = div_reg[set_base + DIV_S];
  // out-of-range P,S,R are passed on unchecked
  assign feedback_ratio = FB_MUL * ({8'h00, active_p_div} + 16'h0001) +
                          {8'h00, active_s_div};

  // ********************
  // checks
  // ********************
  a_rx_mode_entry: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    wr_en_reg && wr_addr_reg == ADDR_MODE_CFG &&
    wr_data_reg[MODE_MSB:MODE_LSB] == MODE_RECEIVE |=> mode_receive)
    else $error("receive mode not entered");
  a_gain_update: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    wr_en_reg && wr_addr_reg == ADDR_GAIN_CFG |=>
    if_amp_gain_sel == $past(wr_data_reg[1:0]))
    else $error("if gain not updated");
  a_filter_bw_update: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    wr_en_reg && wr_addr_reg == ADDR_FILT_BW |=>
    passive_filter_bw_sel == $past(wr_data_reg[7:4]) &&
    second_filter_bw_sel == $past(wr_data_reg[3:0]))
    else $error("filter bandwidths not updated");
  a_bp_select_update: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    wr_en_reg && wr_addr_reg == ADDR_FILT_SEL |=>
    bandpass_filter_select == $past(wr_data_reg[7]))
    else $error("filter type not updated");
  a_center_update: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    wr_en_reg && wr_addr_reg == ADDR_FILT_CTR |=>
    bandpass_center_sel == $past(wr_data_reg[7:4]))
    else $error("centre select not updated");
  a_low_if_gate: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !(mode_receive && bandpass_filter_select) |-> ook_low_if == 8'h00)
    else $error("low IF outside OOK receive");
  a_div_switch: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $changed(divider_set_select) |-> active_ref_div ==
    div_reg[divider_set_select ? DIV_SET_STRIDE : 0])
    else $error("divider set did not switch");
  a_lock_pin_follow: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    lock_en_reg ##1 lock_en_reg |->
    lock_pin == $past(lvl_reg[SYNC_LOCK]))
    else $error("lock pin does not follow lock");
  a_lock_pin_off: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !lock_en_reg |=> !lock_pin)
    else $error("lock pin driven while disabled");
  a_sticky_set: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    rise[SYNC_LOCK] |=> lock_st_reg)
    else $error("lock status not set");
  a_sticky_hold: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    lock_st_reg && !lock_clr |=> lock_st_reg)
    else $error("lock status lost without clear");
endmodule

// file: rtl/rsc_pkg.sv
// constants for the receive and synthesizer configuration register bank
package rsc_pkg;
  // ********************
  // serial port framing
  // ********************
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int CMD_READ_BIT = 7;
  localparam logic [3:0] CNT_CMD_LAST = 4'h7;
  localparam logic [3:0] CNT_DATA_LAST = 4'hF;

  // ********************
  // register offsets
  // ********************
  localparam logic [6:0] ADDR_MODE_CFG = 7'h00;
  localparam logic [6:0] ADDR_GAIN_CFG = 7'h01;
  localparam logic [6:0] ADDR_FDEV_CFG = 7'h02;
  localparam logic [6:0] ADDR_LOCK_CFG = 7'h0E;
  localparam logic [6:0] ADDR_FILT_BW = 7'h10;
  localparam logic [6:0] ADDR_FILT_CTR = 7'h11;
  localparam logic [6:0] ADDR_FILT_SEL = 7'h12;
  localparam logic [6:0] ADDR_DIV_BASE = 7'h1C;
  localparam int DIV_COUNT = 6;
  // divider entries: 0..2 = R,P,S of set one, 3..5 = R,P,S of set two
  localparam int DIV_R = 0;
  localparam int DIV_P = 1;
  localparam int DIV_S = 2;
  localparam int DIV_SET_STRIDE = 3;

  // ********************
  // field positions
  // ********************
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 5;
  localparam int DIV_SEL_BIT = 0;
  localparam int GAIN_MSB = 1;
  localparam int PASSIVE_BW_MSB = 7;
  localparam int PASSIVE_BW_LSB = 4;
  localparam int SECOND_BW_MSB = 3;
  localparam int CENTER_MSB = 7;
  localparam int CENTER_LSB = 4;
  localparam int BP_SEL_BIT = 7;
  localparam int LOCK_EN_BIT = 0;
  localparam int LOCK_ST_BIT = 1;

  // ********************
  // encodings and reset values
  // ********************
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_SYNTH = 3'h2;
  localparam logic [2:0] MODE_RECEIVE = 3'h3;
  localparam logic [2:0] MODE_TRANSMIT = 3'h4;
  localparam logic [15:0] FB_MUL = 16'h004B;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic LOCK_EN_RST = 1'b1;

  // ********************
  // pin synchroniser slots: sck, cs_n, sdi, pll lock
  // ********************
  localparam int SYNC_N = 4;
  localparam int SYNC_SCK = 0;
  localparam int SYNC_CS = 1;
  localparam int SYNC_SDI = 2;
  localparam int SYNC_LOCK = 3;
  localparam logic [3:0] SYNC_RST = 4'h2;

  typedef enum logic [1:0] {RSC_CMD, RSC_DATA, RSC_DONE} rsc_phase_t;
endpackage

// file: tb/rsc_host_model.sv
// serial host model driving the configuration port
module rsc_host_model (
  // clock
  input wire logic ref_clk,
  // serial pins
  output logic sck,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo_out,
  input wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // six cycles keeps margin over the four cycle synchroniser minimum
  task automatic half();
    repeat (6) @(negedge ref_clk);
  endtask

  // msb first; fewer than 16 rises aborts the frame
  task automatic xfer(input logic [15:0] tx, input int nbits,
                      output logic [7:0] rx);
    rx = 8'h00;
    @(negedge ref_clk);
    cs_n = 1'b0;
    half();
    for (int i = 15; i > 15 - nbits; i--) begin
      sdi = tx[i];
      half();
      sck = 1'b1;
      // released line shows the inverse of the last bit
      if (i < 8) rx = {rx[6:0], sdo_oe ? sdo_out : ~rx[0]};
      half();
      sck = 1'b0;
    end
    half();
    cs_n = 1'b1;
    sdi = ~sdi;
    half();
  endtask
endmodule

// file: tb/tb_top.sv
// self-checking bench for the configuration register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rsc_pkg::*;

  logic ref_clk, reset_n, pll_locked, sck, cs_n, sdi, sdo_out, sdo_oe;
  logic lock_pin, mode_sleep, mode_standby, mode_synth, mode_receive;
  logic mode_transmit, bandpass_filter_select, divider_set_select;
  logic [2:0] chip_operating_mode;
  logic [1:0] if_amp_gain_sel;
  logic [3:0] passive_filter_bw_sel, second_filter_bw_sel;
  logic [3:0] bandpass_center_sel;
  logic [7:0] freq_deviation_setting, ook_low_if;
  logic [7:0] active_ref_div, active_p_div, active_s_div;
  logic [15:0] feedback_ratio;
  int failures = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h0000ACDD;
  logic [7:0] d, r, p, s, cr, cp, rx;
  logic [6:0] a;
  logic sel;

  rsc_config_regs i_rsc_config_regs (
    .ref_clk, .reset_n, .sck, .cs_n, .sdi, .sdo_out, .sdo_oe,
    .pll_locked, .lock_pin, .chip_operating_mode, .mode_sleep,
    .mode_standby, .mode_synth, .mode_receive, .mode_transmit,
    .if_amp_gain_sel, .passive_filter_bw_sel, .bandpass_filter_select,
    .second_filter_bw_sel, .bandpass_center_sel, .freq_deviation_setting,
    .ook_low_if, .divider_set_select, .active_ref_div, .active_p_div,
    .active_s_div, .feedback_ratio
  );

  rsc_host_model i_rsc_host_model (
    .ref_clk, .sck, .cs_n, .sdi, .sdo_out, .sdo_oe
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ********************
  // helpers
  // ********************
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic logic [15:0] ratio(input logic [7:0] pv, sv);
    return 16'h004B * ({8'h00, pv} + 16'h0001) + {8'h00, sv};
  endfunction

  function automatic logic [4:0] onehot(input logic [2:0] m);
    return (m < 3'h5) ? (5'h01 << m) : 5'h00;
  endfunction

  task automatic final_report();
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] ad, input logic [7:0] dv);
    logic [7:0] junk;
    i_rsc_host_model.xfer({1'b0, ad, dv}, 16, junk);
  endtask

  task automatic rdchk(input logic [6:0] ad, input logic [7:0] exp);
    logic [7:0] got;
    i_rsc_host_model.xfer({1'b1, ad, 8'h00}, 16, got);
    chk(16'(got), 16'(exp));
  endtask

  task automatic wait_lock(input logic v);
    int n;
    n = 0;
    while (lock_pin !== v && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    chk(16'(lock_pin), 16'(v));
    if (lock_pin !== v) final_report();
  endtask

  // every mapped and unmapped place up to one past the last divider
  task automatic chk_reset();
    for (int i = 0; i < 35; i++) begin
      rdchk(7'(i), (7'(i) == ADDR_LOCK_CFG) ? 8'h01 : 8'h00);
    end
  endtask

  // ********************
  // main sequence
  // ********************
  initial begin
    reset_n = 1'b0;
    pll_locked = 1'b0;
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk_reset();
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_MODE_CFG, {3'(m), 5'h00});
      chk(16'(chip_operating_mode), 16'(m));
      chk(16'({mode_transmit, mode_receive, mode_synth, mode_standby,
               mode_sleep}), 16'(onehot(3'(m))));
      rdchk(ADDR_MODE_CFG, {3'(m), 5'h00});
    end
    repeat (4) begin
      d = rnd();
      wr(ADDR_GAIN_CFG, d);
      chk(16'(if_amp_gain_sel), 16'(d[1:0]));
      rdchk(ADDR_GAIN_CFG, d & 8'h03);
      d = rnd();
      wr(ADDR_FILT_BW, d);
      chk(16'(passive_filter_bw_sel), 16'(d[7:4]));
      chk(16'(second_filter_bw_sel), 16'(d[3:0]));
      rdchk(ADDR_FILT_BW, d);
      d = rnd();
      wr(ADDR_FILT_CTR, d);
      chk(16'(bandpass_center_sel), 16'(d[7:4]));
      rdchk(ADDR_FILT_CTR, d & 8'hF0);
      d = rnd();
      wr(ADDR_FDEV_CFG, d);
      chk(16'(freq_deviation_setting), 16'(d));
    end
    // frequency hopping: load the idle set, then flip the select
    sel = 1'b0;
    {cr, cp} = 16'h0000;
    for (int h = 0; h < 4; h++) begin
      p = rnd();
      s = rnd();
      if (s > p) s = p;
      r = 8'h40 + rnd() % 8'h6A;
      a = ADDR_DIV_BASE + (sel ? 7'h00 : 7'h03);
      wr(a, r);
      wr(a + 7'h01, p);
      wr(a + 7'h02, s);
      chk({active_ref_div, active_p_div}, {cr, cp});
      sel = ~sel;
      wr(ADDR_MODE_CFG, {MODE_RECEIVE, 4'h0, sel});
      chk({active_ref_div, active_p_div}, {r, p});
      chk(16'(active_s_div), 16'(s));
      chk(feedback_ratio, ratio(p, s));
      chk(16'(divider_set_select), 16'(sel));
      rdchk(a + 7'h02, s);
      {cr, cp} = {r, p};
    end
    for (int b = 0; b < 2; b++) begin
      wr(ADDR_FILT_SEL, {1'(b), 7'h7F});
      chk(16'(bandpass_filter_select), 16'(b));
      rdchk(ADDR_FILT_SEL, {1'(b), 7'h00});
      chk(16'(ook_low_if), (b == 1) ? 16'(d) : 16'h0000);
    end
    wr(ADDR_MODE_CFG, {MODE_STANDBY, 5'h00});
    chk(16'(ook_low_if), 16'h0000);
    pll_locked = 1'b1;
    wait_lock(1'b1);
    rdchk(ADDR_LOCK_CFG, 8'h03);
    pll_locked = 1'b0;
    wait_lock(1'b0);
    wr(ADDR_LOCK_CFG, 8'h01);
    rdchk(ADDR_LOCK_CFG, 8'h03);
    wr(ADDR_LOCK_CFG, 8'h03);
    rdchk(ADDR_LOCK_CFG, 8'h01);
    wr(ADDR_LOCK_CFG, 8'h00);
    pll_locked = 1'b1;
    repeat (12) @(negedge ref_clk);
    chk(16'(lock_pin), 16'h0000);
    rdchk(ADDR_LOCK_CFG, 8'h02);
    wr(ADDR_LOCK_CFG, 8'h01);
    wait_lock(1'b1);
    // a frame cut short after 15 rises must leave the register alone
    wr(ADDR_GAIN_CFG, 8'h02);
    i_rsc_host_model.xfer({1'b0, ADDR_GAIN_CFG, 8'h01}, 15, rx);
    rdchk(ADDR_GAIN_CFG, 8'h02);
    wr(ADDR_MODE_CFG, 8'h01);
    reset_n = 1'b0;
    pll_locked = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(16'({lock_pin, divider_set_select}), 16'h0000);
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk_reset();
    final_report();
  end
endmodule
